// >>> src/rcd_consts.vh
// Purpose: Constants for the reference clock divider output block.
// Assumes: One 125 MHz system clock; byte-wide control register.
// Notes: Register sits at index 0 of a small private map.
`ifndef RCD_CONSTS_VH
`define RCD_CONSTS_VH

// Register map
`define RCD_ADDR_W 4
`define RCD_CTRL_ADDR 4'h0
`define RCD_STAT_ADDR 4'h1

// Control register fields and reset value
`define RCD_EN_BIT 7
`define RCD_PIN_EN_BIT 6
`define RCD_SLEW_BIT 5
`define RCD_DUTY_HI 4
`define RCD_DUTY_LO 3
`define RCD_DIV_HI 2
`define RCD_DIV_LO 0
`define RCD_CTRL_RESET 8'h30

// Duty codes
`define RCD_DUTY_0 2'h0
`define RCD_DUTY_25 2'h1
`define RCD_DUTY_50 2'h2
`define RCD_DUTY_75 2'h3

// Divider codes
`define RCD_DIV_1 3'h0
`define RCD_DIV_2 3'h1

// Counter width covers divide by 128
`define RCD_CNT_W 7

`endif

// >>> src/rcd_ctrl_reg.v
// Purpose: Control register store with async reset to its default.
// Assumes: Write strobe is one cycle; the caller masks it during sleep.
// Notes: Reset returns every field to its default value.
`timescale 1ns/1ps
`include "rcd_consts.vh"

module rcd_ctrl_reg (
    input wire clk_in, // System clock
    input wire rst_b_in, // Async reset, active low
    input wire wr_in, // Write strobe
    input wire [7:0] wdata_in, // Write data
    output reg [7:0] ctrl_out // Stored control value
);

    // Register load; reset restores the default
    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ctrl_out <= `RCD_CTRL_RESET;
        end else if (wr_in) begin
            ctrl_out <= wdata_in;
        end
    end

endmodule // rcd_ctrl_reg

// >>> src/rcd_phase_gen.v
// Purpose: Free-running divider counter and phase compare.
// Assumes: Divide code 1..7; code 0 is handled by the caller.
// Notes: Settings latch at period wrap, or every cycle while disabled, so output never glitches.
`timescale 1ns/1ps
`include "rcd_consts.vh"

module rcd_phase_gen (
    input wire clk_in, // System clock
    input wire rst_b_in, // Async reset, active low
    input wire hold_in, // Freeze all state, clock halted in sleep
    input wire run_in, // Module enabled
    input wire [2:0] div_in, // Divide select from register
    input wire [1:0] duty_in, // Duty select from register
    output reg phase_out, // Divided clock, registered
    output reg wrap_out // Pulse at period end
);

    reg [`RCD_CNT_W-1:0] cnt_q;
    reg [2:0] div_q;
    reg [1:0] duty_q;
    reg [`RCD_CNT_W-1:0] last;
    reg [`RCD_CNT_W:0] hi_len;
    reg [`RCD_CNT_W-1:0] cnt_d;
    reg hi_d;
    reg end_d;
    reg [2:0] div_nx;
    reg start_hi;

    // Period end and high-time length from latched settings
    always @* begin
        last = (`RCD_CNT_W'h01 << div_q) - `RCD_CNT_W'h01;
        case (duty_q)
            `RCD_DUTY_25: hi_len = {1'b0, last} + 8'h01 >> 2;
            `RCD_DUTY_50: hi_len = {1'b0, last} + 8'h01 >> 1;
            `RCD_DUTY_75: hi_len = ({1'b0, last} + 8'h01 >> 1)
                + ({1'b0, last} + 8'h01 >> 2);
            default: hi_len = 8'h00;
        endcase
        end_d = (cnt_q == last);
        cnt_d = end_d ? {`RCD_CNT_W{1'b0}} : cnt_q + `RCD_CNT_W'h01;
        hi_d = ({1'b0, cnt_d} < hi_len);
        // First count of the next period judged on the settings about to
        // latch; a quarter of a two-cycle period rounds down to nothing
        div_nx = (div_in == `RCD_DIV_1) ? `RCD_DIV_2 : div_in;
        start_hi = (duty_in != `RCD_DUTY_0)
            && !((duty_in == `RCD_DUTY_25) && (div_nx == `RCD_DIV_2));
    end

    // Counter runs only while enabled; settings taken at wrap.
    // Hold freezes every flop so the outputs keep their level in sleep.
    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cnt_q <= {`RCD_CNT_W{1'b0}};
            div_q <= `RCD_DIV_2;
            duty_q <= `RCD_DUTY_0;
            phase_out <= 1'b0;
            wrap_out <= 1'b0;
        end else if (hold_in) begin
            phase_out <= phase_out;
        end else if (!run_in) begin
            cnt_q <= {`RCD_CNT_W{1'b0}};
            div_q <= div_nx;
            duty_q <= duty_in;
            phase_out <= 1'b0;
            wrap_out <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            wrap_out <= end_d;
            if (end_d) begin
                div_q <= div_nx;
                duty_q <= duty_in;
            end
            phase_out <= end_d ? start_hi : hi_d;
        end
    end

endmodule // rcd_phase_gen

// >>> src/rcd_top.v
// Purpose: Reference clock divider with pin and modulator outputs.
// Assumes: Pin inputs synchronous to clk_in; sleep gates the clock.
// Notes: One divider feeds both the shared pin and the modulator.
`timescale 1ns/1ps
`include "rcd_consts.vh"

module rcd_top (
    input wire clk_in, // System clock, 125 MHz
    input wire rst_b_in, // Async reset, active low
    input wire [`RCD_ADDR_W-1:0] addr_in, // Register address
    input wire [7:0] wdata_in, // Register write data
    input wire wr_in, // Write strobe
    input wire rd_in, // Read strobe
    output reg [7:0] rdata_out, // Read data, cycle after strobe
    input wire sleep_in, // Device in sleep, clock halted
    input wire low_power_crystal_mode_in, // Crystal LP mode
    input wire standard_crystal_mode_in, // Crystal XT mode
    input wire high_speed_crystal_mode_in, // Crystal HS mode
    input wire sysclk_pin_out_enable_n_in, // 0 routes quarter clock
    output wire refclk_out_pin_out, // Shared pin output level
    output wire refclk_out_pin_oe_out, // Shared pin output enable
    output wire refclk_slew_limit_out, // Pin slew limiting on
    output wire sysclk_quarter_pin_out, // Quarter system clock
    output wire modulator_clk_out // Reference clock to modulator
);

    wire [7:0] ctrl;
    wire ctrl_wr;
    wire run;
    wire [2:0] div_sel;
    wire [1:0] duty_sel;
    wire phase;
    wire wrap;
    wire crystal;
    reg [1:0] quarter_q;
    reg ref_q;
    reg [7:0] rdata_d;
    reg pin_q;
    reg oe_q;

    // Field decode; sleep masks control writes and holds the phase, quarter and oe flops since the clock is stopped
    assign ctrl_wr = wr_in && !sleep_in && (addr_in == `RCD_CTRL_ADDR);
    assign run = ctrl[`RCD_EN_BIT];
    assign div_sel = ctrl[`RCD_DIV_HI:`RCD_DIV_LO];
    assign duty_sel = ctrl[`RCD_DUTY_HI:`RCD_DUTY_LO];
    assign crystal = low_power_crystal_mode_in | standard_crystal_mode_in
        | high_speed_crystal_mode_in;

    rcd_ctrl_reg u_ctrl (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .wr_in(ctrl_wr),
        .wdata_in(wdata_in),
        .ctrl_out(ctrl)
    );

    rcd_phase_gen u_phase (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .hold_in(sleep_in),
        .run_in(run),
        .div_in(div_sel),
        .duty_in(duty_sel),
        .phase_out(phase),
        .wrap_out(wrap)
    );

    // Quarter-rate system clock for the clock-out function
    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            quarter_q <= 2'h0;
        end else if (!sleep_in) begin
            quarter_q <= quarter_q + 2'h1;
        end
    end

    assign sysclk_quarter_pin_out = quarter_q[1];

    // Divided reference sourced only from clk_in; no other clock used.
    // Divide by two uses whole cycles, so 25 percent rounds to no high
    // time and 75 to half; undivided output parks low while asleep.
    always @* begin
        if (!run) begin
            ref_q = 1'b0;
        end else if (duty_sel == `RCD_DUTY_0) begin
            ref_q = 1'b0;
        end else if (div_sel == `RCD_DIV_1) begin
            ref_q = clk_in & ~sleep_in;
        end else begin
            ref_q = phase;
        end
    end

    // Modulator always gets the clock, pin or no pin
    assign modulator_clk_out = ref_q;

    // Pin mux: crystal blocks, clock-out has priority, then reference
    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            oe_q <= 1'b0;
        end else if (!sleep_in) begin
            if (crystal) begin
                oe_q <= 1'b0;
            end else if (!sysclk_pin_out_enable_n_in) begin
                oe_q <= 1'b1;
            end else begin
                oe_q <= ctrl[`RCD_PIN_EN_BIT];
            end
        end
    end

    // Pin level; the undivided case must be combinational to pass clk_in
    always @* begin
        if (crystal) begin
            pin_q = 1'b0;
        end else if (!sysclk_pin_out_enable_n_in) begin
            pin_q = quarter_q[1];
        end else if (ctrl[`RCD_PIN_EN_BIT]) begin
            pin_q = ref_q;
        end else begin
            pin_q = 1'b0;
        end
    end

    assign refclk_out_pin_out = pin_q;
    assign refclk_out_pin_oe_out = oe_q;
    assign refclk_slew_limit_out = ctrl[`RCD_SLEW_BIT];

    // Read mux; status shows running state and period wrap
    always @* begin
        if (addr_in == `RCD_CTRL_ADDR) begin
            rdata_d = ctrl;
        end else if (addr_in == `RCD_STAT_ADDR) begin
            rdata_d = {4'h0, wrap, oe_q, phase, run};
        end else begin
            rdata_d = 8'h00;
        end
    end

    // Read data registered, valid one cycle after the strobe
    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rdata_out <= 8'h00;
        end else if (rd_in) begin
            rdata_out <= rdata_d;
        end else begin
            rdata_out <= 8'h00;
        end
    end

endmodule // rcd_top

// >>> verif/rcd_top_sva.sv
// Purpose: Port checker for rcd_top.
// Assumes: Control at address 0, reset 8'h30.
// Notes: Shadows control from bus writes.
`timescale 1ns/1ps
module rcd_top_sva (
    input wire clk_in, // Clock
    input wire rst_b_in, // Reset
    input wire [3:0] addr_in, // Address
    input wire [7:0] wdata_in, // Data
    input wire wr_in, // Write
    input wire rd_in, // Read
    input wire [7:0] rdata_out, // Read data
    input wire sleep_in, // Sleep
    input wire low_power_crystal_mode_in, // Mode
    input wire standard_crystal_mode_in, // Mode
    input wire high_speed_crystal_mode_in, // Mode
    input wire sysclk_pin_out_enable_n_in, // Clock-out
    input wire refclk_out_pin_oe_out, // Pin oe
    input wire refclk_slew_limit_out, // Slew
    input wire sysclk_quarter_pin_out, // Quarter
    input wire modulator_clk_out // Modulator
);
    reg [7:0] shd_q;
    wire xtal = low_power_crystal_mode_in | standard_crystal_mode_in |
        high_speed_crystal_mode_in;
    // Shadow skips sleep writes, as the block freezes them
    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in)
            shd_q <= 8'h30;
        else if (wr_in && !sleep_in && addr_in == 4'h0)
            shd_q <= wdata_in;
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    sequence s_xtal;
        xtal ##1 xtal;
    endsequence
    // Oe is registered, so the mode must have stood a cycle
    chk_xtal_no_oe: assert property (s_xtal |-> !refclk_out_pin_oe_out)
        else $error("pin driven in crystal mode");
    chk_read_ctrl: assert property (rd_in && addr_in == 4'h0 |=>
        rdata_out == shd_q) else $error("control readback wrong");
    chk_read_idle: assert property (!rd_in |=> rdata_out == 8'h00)
        else $error("read data not cleared");
    chk_read_unmapped: assert property (rd_in && addr_in > 4'h1 |=>
        rdata_out == 8'h00) else $error("unmapped read not zero");
    chk_slew_bit: assert property (refclk_slew_limit_out == shd_q[5])
        else $error("slew output differs from control");
    chk_off_low: assert property (!shd_q[7] && !$past(shd_q[7]) |->
        !modulator_clk_out) else $error("clock runs while disabled");
    chk_oe_source: assert property (refclk_out_pin_oe_out &&
        $past(sysclk_pin_out_enable_n_in) |-> $past(shd_q[6]))
        else $error("pin driven without pin enable");
    chk_quarter_rate: assert property ($past(rst_b_in) &&
        $past(rst_b_in, 2) && !sleep_in && !$past(sleep_in) &&
        !$past(sleep_in, 2) |->
        sysclk_quarter_pin_out != $past(sysclk_quarter_pin_out, 2))
        else $error("quarter clock rate wrong");
    chk_sleep_hold: assert property (sleep_in && $past(sleep_in) &&
        shd_q[2:0] != 3'h0 |-> $stable(modulator_clk_out))
        else $error("clock moved in sleep");
endmodule // rcd_top_sva
bind rcd_top rcd_top_sva i_chk (.*);

// >>> verif/rcd_ext_dev.sv
// Purpose: External device clocked from the shared pin.
// Assumes: Pin has a pull-up, so a released pin reads high.
// Notes: Counts rising edges; only differences matter.
`timescale 1ns/1ps
module rcd_ext_dev (
    input wire pin_in, // Pin level
    output reg [15:0] edges_out // Rising edges seen
);
    // Count every rising edge the device would clock on
    initial edges_out = 16'h0000;
    always @(posedge pin_in) edges_out <= edges_out + 16'h0001;
endmodule // rcd_ext_dev

// >>> verif/reference_clock_divider_output_tb.sv
// Purpose: Self-checking bench for rcd_top.
// Assumes: Control at 0; read data one cycle after strobe.
// Notes: Reads are noted in a queue and checked by a monitor.
`timescale 1ns/1ps
module reference_clock_divider_output_tb;
    reg clk_in = 1'b0;
    reg rst_b_in = 1'b0;
    reg [3:0] addr_in = 4'h0;
    reg [7:0] wdata_in = 8'h00;
    reg wr_in = 1'b0, rd_in = 1'b0, sleep_in = 1'b0, rd_d = 1'b0;
    reg lp = 1'b0, xt = 1'b0, hs = 1'b0, clko_n = 1'b1;
    wire [7:0] rdata_out;
    wire pin, oe, mod;
    wire [15:0] edges;
    wire pin_w = oe ? pin : 1'b1; // Pull-up while released
    reg [7:0] exp_q[$];
    integer err_total = 0, checked = 0, cyc = 0, i, j, n;
    always #4 clk_in = ~clk_in;
    rcd_top i_dut (.clk_in(clk_in), .rst_b_in(rst_b_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
        .rd_in(rd_in), .rdata_out(rdata_out), .sleep_in(sleep_in),
        .low_power_crystal_mode_in(lp), .standard_crystal_mode_in(xt),
        .high_speed_crystal_mode_in(hs),
        .sysclk_pin_out_enable_n_in(clko_n), .refclk_out_pin_out(pin),
        .refclk_out_pin_oe_out(oe), .refclk_slew_limit_out(),
        .sysclk_quarter_pin_out(), .modulator_clk_out(mod));
    rcd_ext_dev i_ext (.pin_in(pin_w), .edges_out(edges));
    task chk(input [15:0] got, input [15:0] exp);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("ERROR %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    // Strobes are set every call, so none is assigned twice an edge
    task bus(input w, r, input [3:0] a, input [7:0] d, e);
        begin
            wr_in <= w;
            rd_in <= r;
            addr_in <= a;
            wdata_in <= d;
            if (r) exp_q.push_back(e);
            @(posedge clk_in);
        end
    endtask
    // Settings latch at wrap, so wait past the longest period first
    task run(input [7:0] c, input [15:0] hx, ex);
        reg [15:0] h, e0;
        begin
            bus(1, 0, 4'h0, c, 8'h00);
            bus(0, 0, 4'h0, 8'h00, 8'h00);
            repeat (260) @(posedge clk_in);
            #2;
            h = 0;
            e0 = edges;
            repeat (4 << c[2:0]) begin
                if (mod === 1'b1) h = h + 1;
                @(posedge clk_in);
                #2;
            end
            chk(h, hx);
            chk(edges - e0, ex);
            @(posedge clk_in);
        end
    endtask
    task summarize;
        begin
            $display("Checks %0d errors %0d", checked, err_total);
            if (err_total == 0 && checked > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    // Monitor takes the oldest note whenever read data is due
    always @(posedge clk_in) begin
        rd_d <= rd_in & rst_b_in;
        if (rd_d) chk(rdata_out, exp_q.pop_front());
        cyc = cyc + 1;
        if (cyc == 40000) begin
            err_total = err_total + 1;
            summarize;
        end
    end
    initial begin
        n = $urandom(69364);
        repeat (6) @(posedge clk_in);
        rst_b_in <= 1'b1;
        @(posedge clk_in);
        n = $urandom;
        bus(0, 1, 4'h0, 8'h00, 8'h30);
        bus(1, 0, 4'h0, n[7:0], 8'h00);
        bus(0, 1, 4'h0, 8'h00, n[7:0]);
        bus(1, 0, 4'h2 | n[11:8], 8'hFF, 8'h00);
        bus(0, 1, 4'h2 | n[11:8], 8'h00, 8'h00);
        for (i = 0; i < 8; i = i + 1)
            for (j = 0; j < 4; j = j + 1)
                if (i != 1 || j == 0 || j == 2)
                    run({3'b110, j[1:0], i[2:0]}, i ? j << i : (j ? 4 : 0),
                        j ? 4 : 0);
        clko_n <= 1'b0;
        run(8'hD3, 16, 8);
        clko_n <= 1'b1;
        for (i = 0; i < 3; i = i + 1) begin
            {hs, xt, lp} <= 3'b001 << i;
            run(8'hD2, 8, 0);
        end
        {hs, xt, lp} <= 3'b000;
        run(8'hB2, 8, 0);
        run(8'h52, 0, 0);
        bus(0, 1, 4'h1, 8'h00, 8'h04);
        bus(1, 0, 4'h0, 8'hD5, 8'h00);
        repeat (40) @(posedge clk_in);
        sleep_in <= 1'b1;
        bus(1, 0, 4'h0, 8'hFF, 8'h00);
        bus(0, 1, 4'h0, 8'h00, 8'hD5);
        bus(0, 0, 4'h0, 8'h00, 8'h00);
        #2 n = mod;
        // Half a period apart, so a running clock could not look held
        repeat (16) @(posedge clk_in);
        #2 chk({15'h0000, mod}, n[15:0]);
        @(posedge clk_in);
        sleep_in <= 1'b0;
        rst_b_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        rst_b_in <= 1'b1;
        @(posedge clk_in);
        bus(0, 1, 4'h0, 8'h00, 8'h30);
        bus(0, 0, 4'h0, 8'h00, 8'h00);
        #2 chk({15'h0000, mod}, 16'h0000);
        repeat (2) @(posedge clk_in);
        summarize;
    end
endmodule // reference_clock_divider_output_tb
